// ==== rtl/readback_pkg.sv ====
// Purpose: Shared constants for the legacy state readback block
// Assumes: Eight-bit I/O decode, eight-bit data
// Notes:   Masks give the fixed values of reserved controller bits
package readback_pkg;

  localparam logic [7:0] PORT_DMA_LOW_STATUS  = 8'h08;
  localparam logic [7:0] PORT_IRQ_MASTER      = 8'h20;
  localparam logic [7:0] PORT_TIMER0          = 8'h40;
  localparam logic [7:0] PORT_TIMER2          = 8'h42;
  localparam logic [7:0] PORT_CLOCK_INDEX     = 8'h70;
  localparam logic [7:0] PORT_DMA_HIGH_STATUS = 8'hd0;

  // Base/current address and count ports of the two DMA controllers
  localparam logic [7:0] DMA_LOW_REG_FIRST    = 8'h00;
  localparam logic [7:0] DMA_LOW_REG_LAST     = 8'h07;
  localparam logic [7:0] DMA_HIGH_REG_FIRST   = 8'hc0;
  localparam logic [7:0] DMA_HIGH_REG_LAST    = 8'hcf;

  localparam int IRQ_READ_COUNT   = 12;
  localparam int TIMER_READ_COUNT = 7;
  localparam int IRQ_IDX_W        = 4;
  localparam int TIMER_IDX_W      = 3;
  localparam int WORDS_PER_CTRL   = 6;
  localparam int STATUS_W         = 6;
  localparam int CLOCK_INDEX_W    = 7;

  localparam logic [IRQ_IDX_W-1:0] IRQ_SLAVE_FIRST = 4'h6;

  localparam logic [TIMER_IDX_W-1:0] TMR_C0_STATUS = 3'h0;
  localparam logic [TIMER_IDX_W-1:0] TMR_C0_LOW    = 3'h1;
  localparam logic [TIMER_IDX_W-1:0] TMR_C0_HIGH   = 3'h2;
  localparam logic [TIMER_IDX_W-1:0] TMR_C2_LOW    = 3'h5;
  localparam logic [TIMER_IDX_W-1:0] TMR_C2_HIGH   = 3'h6;

  // Controller word order within one controller's read sequence
  typedef enum logic [2:0] {
    WORD_INIT_TWO   = 3'b000,
    WORD_INIT_THREE = 3'b001,
    WORD_INIT_FOUR  = 3'b010,
    WORD_MASK_OP    = 3'b011,
    WORD_OP_TWO     = 3'b100,
    WORD_OP_THREE   = 3'b101
  } pic_word_e;

  localparam logic [7:0] INIT_TWO_KEEP  = 8'hf8;
  localparam logic [7:0] INIT_FOUR_KEEP = 8'h12;
  localparam logic [7:0] OP_TWO_KEEP    = 8'he7;
  localparam logic [7:0] OP_THREE_KEEP  = 8'h47;
  localparam logic [7:0] OP_THREE_SET   = 8'h08;
  localparam int         OP_THREE_SRC   = 6;
  localparam int         OP_THREE_DST   = 5;

endpackage : readback_pkg

// ==== rtl/seq_pointer.sv ====
// Purpose: Per-port read sequence pointer
// Assumes: restart held while the mode is off
// Notes:   Wraps to zero after the last access
`timescale 1ns/1ps
module seq_pointer #(
  parameter int COUNT = 12,
  parameter int W     = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         restart,
  input  wire logic         step,
  output logic      [W-1:0] idx
);

  logic [W-1:0] next_idx;

  always_comb
  begin
    next_idx = idx;
    if (restart)
    begin
      next_idx = '0;
    end
    else if (step)
    begin
      if (idx == W'(COUNT - 1))
      begin
        next_idx = '0;
      end
      else
      begin
        next_idx = idx + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      idx <= '0;
    end
    else
    begin
      idx <= next_idx;
    end
  end

endmodule : seq_pointer

// ==== rtl/pic_word_format.sv ====
// Purpose: Forces reserved bits of a controller word to fixed values
// Assumes: kind selects the word position in the sequence
// Notes:   Purely combinational
`timescale 1ns/1ps
module pic_word_format
  import readback_pkg::*;
(
  input  wire pic_word_e       kind,
  input  wire logic      [7:0] raw,
  output logic           [7:0] shown
);

  always_comb
  begin
    shown = raw;
    unique case (kind)
      WORD_INIT_TWO:   shown = raw & INIT_TWO_KEEP;
      WORD_INIT_THREE: shown = raw;
      WORD_INIT_FOUR:  shown = raw & INIT_FOUR_KEEP;
      WORD_MASK_OP:    shown = raw;
      WORD_OP_TWO:     shown = raw & OP_TWO_KEEP;
      WORD_OP_THREE:
      begin
        shown               = (raw & OP_THREE_KEEP) | OP_THREE_SET;
        shown[OP_THREE_DST] = raw[OP_THREE_SRC];
      end
      default:         shown = '0;
    endcase
  end

endmodule : pic_word_format

// ==== rtl/legacy_state_readback.sv ====
// Purpose: Alternate access readback and restore paths for legacy I/O
// Assumes: Host I/O strobes and shadow inputs on sys_clk
// Notes:   Read data and strobes appear one cycle after the request
`timescale 1ns/1ps
module legacy_state_readback
  import readback_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     alternate_access_mode,
  input  wire logic [7:0]               io_addr,
  input  wire logic                     io_rd,
  input  wire logic                     io_wr,
  input  wire logic [7:0]               io_wdata,
  output logic      [7:0]               io_rdata,
  output logic                          io_rvalid,
  output logic                          io_rhit,
  input  wire logic [7:0]               master_word [WORDS_PER_CTRL],
  input  wire logic [7:0]               slave_word  [WORDS_PER_CTRL],
  input  wire logic [STATUS_W-1:0]      timer0_status,
  input  wire logic [15:0]              timer0_base_count,
  input  wire logic [STATUS_W-1:0]      timer2_status,
  input  wire logic [15:0]              timer2_base_count,
  input  wire logic [CLOCK_INDEX_W-1:0] clock_index,
  input  wire logic                     nmi_enable,
  output logic                          dma_low_status_load,
  output logic                          dma_high_status_load,
  output logic      [7:0]               dma_status_data,
  output logic                          dma_base_we,
  output logic                          dma_current_we,
  output logic      [7:0]               dma_reg_addr,
  output logic      [7:0]               dma_reg_data
);

  logic [IRQ_IDX_W-1:0]   irq_idx;
  logic [TIMER_IDX_W-1:0] timer_idx;
  logic                   rd_irq;
  logic                   rd_timer;
  logic                   rd_timer2;
  logic                   rd_clock;
  logic                   wr_dma_reg;
  logic                   slave_sel;
  logic [2:0]             word_pos;
  logic [7:0]             raw_word;
  logic [7:0]             shown_word;
  logic [7:0]             next_rdata;
  logic                   next_rhit;
  logic                   next_low_load;
  logic                   next_high_load;
  logic                   next_base_we;
  logic                   next_current_we;

  assign rd_irq    = alternate_access_mode && io_rd && io_addr == PORT_IRQ_MASTER;
  assign rd_timer  = alternate_access_mode && io_rd && io_addr == PORT_TIMER0;
  assign rd_timer2 = alternate_access_mode && io_rd && io_addr == PORT_TIMER2;
  assign rd_clock  = alternate_access_mode && io_rd && io_addr == PORT_CLOCK_INDEX;
  assign wr_dma_reg = io_wr
                      && ((io_addr >= DMA_LOW_REG_FIRST && io_addr <= DMA_LOW_REG_LAST)
                      || (io_addr >= DMA_HIGH_REG_FIRST && io_addr <= DMA_HIGH_REG_LAST));

  seq_pointer #(
    .COUNT (IRQ_READ_COUNT),
    .W     (IRQ_IDX_W)
  ) irq_pointer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .restart (!alternate_access_mode),
    .step    (rd_irq),
    .idx     (irq_idx)
  );

  seq_pointer #(
    .COUNT (TIMER_READ_COUNT),
    .W     (TIMER_IDX_W)
  ) timer_pointer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .restart (!alternate_access_mode),
    .step    (rd_timer),
    .idx     (timer_idx)
  );

  // Master words first, then slave words
  assign slave_sel = irq_idx >= IRQ_SLAVE_FIRST;
  assign word_pos  = slave_sel ? 3'(irq_idx - IRQ_SLAVE_FIRST) : 3'(irq_idx);
  assign raw_word  = slave_sel ? slave_word[word_pos] : master_word[word_pos];

  pic_word_format irq_format (
    .kind  (pic_word_e'(word_pos)),
    .raw   (raw_word),
    .shown (shown_word)
  );

  always_comb
  begin
    next_rdata = '0;
    next_rhit  = 1'b1;
    if (rd_irq)
    begin
      next_rdata = shown_word;
    end
    else if (rd_timer)
    begin
      unique case (timer_idx)
        TMR_C0_STATUS: next_rdata = {2'h0, timer0_status};
        TMR_C0_LOW:    next_rdata = timer0_base_count[7:0];
        TMR_C0_HIGH:   next_rdata = timer0_base_count[15:8];
        TMR_C2_LOW:    next_rdata = timer2_base_count[7:0];
        TMR_C2_HIGH:   next_rdata = timer2_base_count[15:8];
        default:       next_rdata = '0;
      endcase
    end
    else if (rd_timer2)
    begin
      next_rdata = {2'h0, timer2_status};
    end
    else if (rd_clock)
    begin
      next_rdata = {nmi_enable, clock_index};
    end
    else
    begin
      next_rhit = 1'b0;
    end
  end

  always_comb
  begin
    next_low_load   = alternate_access_mode && io_wr && io_addr == PORT_DMA_LOW_STATUS;
    next_high_load  = alternate_access_mode && io_wr && io_addr == PORT_DMA_HIGH_STATUS;
    next_base_we    = wr_dma_reg && !alternate_access_mode;
    next_current_we = wr_dma_reg;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      io_rdata             <= '0;
      io_rvalid            <= 1'b0;
      io_rhit              <= 1'b0;
      dma_low_status_load  <= 1'b0;
      dma_high_status_load <= 1'b0;
      dma_status_data      <= '0;
      dma_base_we          <= 1'b0;
      dma_current_we       <= 1'b0;
      dma_reg_addr         <= '0;
      dma_reg_data         <= '0;
    end
    else
    begin
      io_rdata             <= next_rdata;
      io_rvalid            <= io_rd;
      io_rhit              <= io_rd && next_rhit;
      dma_low_status_load  <= next_low_load;
      dma_high_status_load <= next_high_load;
      dma_status_data      <= io_wdata;
      dma_base_we          <= next_base_we;
      dma_current_we       <= next_current_we;
      dma_reg_addr         <= io_addr;
      dma_reg_data         <= io_wdata;
    end
  end

  // Checks
  logic [IRQ_IDX_W-1:0] last_irq_idx;

  // Sequence positions watched by the checks
  localparam logic [IRQ_IDX_W-1:0]   IRQ_MASTER_MASK = IRQ_IDX_W'(WORD_MASK_OP);
  localparam logic [IRQ_IDX_W-1:0]   IRQ_MASTER_OP3  = IRQ_IDX_W'(WORD_OP_THREE);
  localparam logic [IRQ_IDX_W-1:0]   IRQ_SLAVE_OP3   = IRQ_SLAVE_FIRST + IRQ_MASTER_OP3;
  localparam logic [IRQ_IDX_W-1:0]   IRQ_LAST        = IRQ_IDX_W'(IRQ_READ_COUNT - 1);
  localparam logic [TIMER_IDX_W-1:0] TMR_LAST        = TIMER_IDX_W'(TIMER_READ_COUNT - 1);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      last_irq_idx <= '0;
    end
    else
    begin
      last_irq_idx <= irq_idx;
    end
  end

  clock_index_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_clock |=> io_rvalid && io_rhit
      && io_rdata == {$past(nmi_enable), $past(clock_index)})
    else $error("clock index readback wrong");

  timer2_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_timer2 |=> io_rhit && io_rdata == {2'h0, $past(timer2_status)})
    else $error("counter 2 status readback wrong");

  timer0_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_timer && timer_idx == TMR_C0_STATUS |=> io_rdata == {2'h0, $past(timer0_status)})
    else $error("counter 0 status readback wrong");

  irq_init_two_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && irq_idx == '0 |=> io_rdata == ($past(master_word[0]) & INIT_TWO_KEEP))
    else $error("first controller word wrong");

  op_three_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && (irq_idx == IRQ_MASTER_OP3 || irq_idx == IRQ_SLAVE_OP3)
      |=> !io_rdata[7] && io_rdata[4:3] == 2'h1 && io_rdata[5] == io_rdata[6])
    else $error("operation word three reserved bits wrong");

  irq_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && irq_idx != IRQ_LAST |=> irq_idx == last_irq_idx + IRQ_IDX_W'(1))
    else $error("read pointer did not advance");

  seq_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !alternate_access_mode |=> irq_idx == '0 && timer_idx == '0)
    else $error("read pointer not restarted");

  normal_no_hit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    io_rd && !alternate_access_mode |=> io_rvalid && !io_rhit)
    else $error("readback answered outside alternate mode");

  dma_status_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    alternate_access_mode && io_wr && io_addr == PORT_DMA_LOW_STATUS
      |=> dma_low_status_load && dma_status_data == $past(io_wdata))
    else $error("DMA status load missing");

  base_also_current_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_dma_reg |=> dma_current_we && dma_base_we == !$past(alternate_access_mode))
    else $error("DMA base/current write pairing wrong");

  read_valid_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    io_rd |=> io_rvalid)
    else $error("read not answered");

  miss_reads_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    io_rd && !(rd_irq || rd_timer || rd_timer2 || rd_clock)
      |=> !io_rhit && io_rdata == '0)
    else $error("unmapped read returned data");

  master_mask_word_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && irq_idx == IRQ_MASTER_MASK |=> io_rdata == $past(master_word[WORD_MASK_OP]))
    else $error("master mask word wrong");

  slave_init_two_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && irq_idx == IRQ_SLAVE_FIRST
      |=> io_rdata == ($past(slave_word[WORD_INIT_TWO]) & INIT_TWO_KEEP))
    else $error("first slave word wrong");

  init_four_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && word_pos == WORD_INIT_FOUR |=> (io_rdata & ~INIT_FOUR_KEEP) == '0)
    else $error("init word four reserved bits wrong");

  op_two_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && word_pos == WORD_OP_TWO |=> (io_rdata & ~OP_TWO_KEEP) == '0)
    else $error("operation word two reserved bits wrong");

  timer0_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_timer && timer_idx == TMR_C0_LOW |=> io_rdata == $past(timer0_base_count[7:0]))
    else $error("counter 0 low byte wrong");

  timer2_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_timer && timer_idx == TMR_C2_HIGH |=> io_rdata == $past(timer2_base_count[15:8]))
    else $error("counter 2 high byte wrong");

  high_status_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    alternate_access_mode && io_wr && io_addr == PORT_DMA_HIGH_STATUS
      |=> dma_high_status_load && dma_status_data == $past(io_wdata))
    else $error("DMA high status load missing");

  normal_no_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !alternate_access_mode && io_wr |=> !dma_low_status_load && !dma_high_status_load)
    else $error("DMA status loaded outside alternate mode");

  dma_reg_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_dma_reg
      |=> dma_reg_addr == $past(io_addr) && dma_reg_data == $past(io_wdata))
    else $error("DMA register address or data wrong");

  timer_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_timer && timer_idx != TMR_LAST |=> timer_idx == $past(timer_idx) + TIMER_IDX_W'(1))
    else $error("timer read pointer did not advance");

  irq_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && irq_idx == IRQ_LAST |=> irq_idx == '0)
    else $error("controller read pointer did not wrap");

  full_irq_walk_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rd_irq && irq_idx == IRQ_LAST);

  timer_walk_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rd_timer && timer_idx == TMR_C2_HIGH);

  status_restore_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    dma_high_status_load);

  normal_base_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    dma_base_we && dma_current_we);

  clock_read_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rd_clock);

endmodule : legacy_state_readback

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for legacy_state_readback
// Assumes: Inputs change at the falling edge, answers seen one cycle later
// Notes:   Shadow inputs hold fixed patterns that expose reserved bits
`timescale 1ns/1ps
module tb
  import readback_pkg::*;
;
  logic                     sys_clk;
  logic                     sys_rst;
  logic                     alternate_access_mode;
  logic [7:0]               io_addr;
  logic                     io_rd;
  logic                     io_wr;
  logic [7:0]               io_wdata;
  logic [7:0]               io_rdata;
  logic                     io_rvalid;
  logic                     io_rhit;
  logic [7:0]               master_word [WORDS_PER_CTRL];
  logic [7:0]               slave_word  [WORDS_PER_CTRL];
  logic [STATUS_W-1:0]      timer0_status;
  logic [15:0]              timer0_base_count;
  logic [STATUS_W-1:0]      timer2_status;
  logic [15:0]              timer2_base_count;
  logic [CLOCK_INDEX_W-1:0] clock_index;
  logic                     nmi_enable;
  logic                     dma_low_status_load;
  logic                     dma_high_status_load;
  logic [7:0]               dma_status_data;
  logic                     dma_base_we;
  logic                     dma_current_we;
  logic [7:0]               dma_reg_addr;
  logic [7:0]               dma_reg_data;
  int                       n_fail;
  int                       compares;
  int                       cycles = 0;

  legacy_state_readback i_legacy_state_readback (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .alternate_access_mode(alternate_access_mode),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .io_rhit(io_rhit),
    .master_word(master_word), .slave_word(slave_word),
    .timer0_status(timer0_status), .timer0_base_count(timer0_base_count),
    .timer2_status(timer2_status), .timer2_base_count(timer2_base_count),
    .clock_index(clock_index), .nmi_enable(nmi_enable),
    .dma_low_status_load(dma_low_status_load), .dma_high_status_load(dma_high_status_load),
    .dma_status_data(dma_status_data), .dma_base_we(dma_base_we),
    .dma_current_we(dma_current_we), .dma_reg_addr(dma_reg_addr), .dma_reg_data(dma_reg_data)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Cycle ceiling against hangs
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize;
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Controller word as it must read back, k is position within one controller
  function automatic logic [7:0] fmt(input int k, input logic [7:0] r);
    case (k)
      0:       return {r[7:3], 3'b000};
      2:       return {3'b000, r[4], 2'b00, r[1], 1'b0};
      4:       return {r[7:5], 2'b00, r[2:0]};
      5:       return {1'b0, r[6], r[6], 2'b01, r[2:0]};
      default: return r;
    endcase
  endfunction : fmt

  task automatic idle;
    io_rd = 1'b0;
    io_wr = 1'b0;
    @(negedge sys_clk);
  endtask : idle

  task automatic rd(input logic [7:0] a, input logic hit, input logic [7:0] exp);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge sys_clk);
    chk("io_rvalid", {7'h00, io_rvalid}, 8'h01);
    chk("io_rhit", {7'h00, io_rhit}, {7'h00, hit});
    chk("io_rdata", io_rdata, exp);
  endtask : rd

  // exp holds low load, high load, base write, current write
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] exp);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(negedge sys_clk);
    chk("dma strobes", {4'h0, dma_low_status_load, dma_high_status_load, dma_base_we,
        dma_current_we}, {4'h0, exp});
    if (exp[3] || exp[2])
      chk("dma_status_data", dma_status_data, d);
    if (exp[1] || exp[0])
    begin
      chk("dma_reg_addr", dma_reg_addr, a);
      chk("dma_reg_data", dma_reg_data, d);
    end
  endtask : wr

  task automatic t_pic;
    logic [7:0] raw;
    rd(8'h21, 1'b0, 8'h00);
    alternate_access_mode = 1'b1;
    idle();
    for (int i = 0; i < IRQ_READ_COUNT; i++)
    begin
      raw = (i < WORDS_PER_CTRL) ? master_word[i] : slave_word[i - WORDS_PER_CTRL];
      rd(PORT_IRQ_MASTER, 1'b1, fmt(i % WORDS_PER_CTRL, raw));
    end
    rd(PORT_IRQ_MASTER, 1'b1, fmt(0, master_word[0]));
    idle();
  endtask : t_pic

  task automatic t_timer;
    logic [7:0] exp [7];
    exp = '{8'h2b, 8'h34, 8'h12, 8'h00, 8'h00, 8'hef, 8'hbe};
    for (int i = 0; i < 8; i++)
      rd(PORT_TIMER0, 1'b1, exp[i % 7]);
    rd(PORT_TIMER2, 1'b1, 8'h15);
    rd(PORT_CLOCK_INDEX, 1'b1, 8'hdd);
    idle();
  endtask : t_timer

  task automatic t_restart;
    alternate_access_mode = 1'b0;
    idle();
    rd(PORT_IRQ_MASTER, 1'b0, 8'h00);
    rd(PORT_TIMER0, 1'b0, 8'h00);
    idle();
    alternate_access_mode = 1'b1;
    idle();
    rd(8'h21, 1'b0, 8'h00);
    rd(PORT_IRQ_MASTER, 1'b1, fmt(0, master_word[0]));
    rd(PORT_IRQ_MASTER, 1'b1, fmt(1, master_word[1]));
    rd(PORT_TIMER0, 1'b1, 8'h2b);
    idle();
  endtask : t_restart

  // Reset in mid-run while the mode stays on
  task automatic t_reset;
    sys_rst = 1'b1;
    idle();
    idle();
    sys_rst = 1'b0;
    idle();
    rd(PORT_IRQ_MASTER, 1'b1, fmt(0, master_word[0]));
    rd(PORT_TIMER0, 1'b1, 8'h2b);
    idle();
  endtask : t_reset

  task automatic t_dma;
    wr(PORT_DMA_LOW_STATUS, 8'ha5, 4'b1000);
    wr(PORT_DMA_HIGH_STATUS, 8'h3c, 4'b0100);
    wr(8'h03, 8'h77, 4'b0001);
    idle();
    alternate_access_mode = 1'b0;
    idle();
    wr(PORT_DMA_LOW_STATUS, 8'h11, 4'b0000);
    wr(PORT_DMA_HIGH_STATUS, 8'h22, 4'b0000);
    wr(DMA_LOW_REG_LAST, 8'h5e, 4'b0011);
    wr(DMA_HIGH_REG_FIRST, 8'he2, 4'b0011);
    wr(DMA_HIGH_REG_LAST, 8'h9c, 4'b0011);
    wr(8'h10, 8'h44, 4'b0000);
    wr(8'h02, 8'h40, 4'b0011);
    idle();
    alternate_access_mode = 1'b1;
    idle();
    wr(8'h02, 8'h3a, 4'b0001);
    idle();
  endtask : t_dma

  initial
  begin
    n_fail = 0;
    compares = 0;
    sys_rst = 1'b1;
    alternate_access_mode = 1'b0;
    io_addr = 8'h00;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
    master_word = '{8'hff, 8'h81, 8'hff, 8'h5a, 8'hff, 8'hff};
    slave_word = '{8'h07, 8'h3c, 8'hed, 8'ha5, 8'h18, 8'hb0};
    timer0_status = 6'h2b;
    timer0_base_count = 16'h1234;
    timer2_status = 6'h15;
    timer2_base_count = 16'hbeef;
    clock_index = 7'h5d;
    nmi_enable = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("reset outputs", {io_rvalid, io_rhit, dma_low_status_load, dma_high_status_load,
        dma_base_we, dma_current_we, 2'b00}, 8'h00);
    chk("reset io_rdata", io_rdata, 8'h00);
    sys_rst = 1'b0;
    idle();
    t_pic();
    t_timer();
    t_restart();
    t_reset();
    t_dma();
    summarize();
  end
endmodule : tb
